// file: rtl/flhc_ctrl.sv
/*
  host controller for a byte-wide block-erasable flash, driving its pins
  and reached by software over a plain strobe port.
  assumes the flash obeys its bus timing; data and ready pins are asynchronous.
*/
// Chosen here: the plain strobed port.
// Contract
// R1 - reset pin low clears status, array mode
// R2 - status byte; device owns ready and suspend
// R3 - error bits held until clear command
// R4 - errors accumulate across several writes
// R5 - ready output high idle, low busy
// R6 - commands accepted while busy, subset honoured; the model ignores every command while rdy is low
// R7 - erase by block, byte random access
// R8 - array read: we high, oe ce low
// R9 - array read mode after reset
// R10 - status latched on enable fall, toggle refreshes
// R11 - reads return status during and after operations
// R12 - id at address zero and one
// R13 - command: oe high, ce we low, latch rising
// R14 - write clears bits; erase restores ones
// R15 - write cycle directly follows write setup
// R16 - read-status command selects status path
// R17 - read-id command selects id path
// R18 - device counts attempts, verifies, updates status; the model only ORs fail_wr and no_supply into its error bits
// R19 - status bit layout: 7 ready down to 3
// R20 - read-array returns to array mode
// R21 - erase setup then confirm with block address
// R22 - write setup accepts two codes
`timescale 1ns/1ps
`default_nettype none
`include "flhc_params.svh"
module flhc_ctrl
  import flhc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // software port
  input wire logic [3:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [31:0] sw_rdata,
  // flash pins
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic [20:0] byte_address,
  output logic [7:0] data_bus_out,
  output logic data_bus_oe,
  input wire logic [7:0] data_bus_in,
  output logic reset_powerdown_n,
  input wire logic ready_busy_out
);
  localparam logic [7:0] SETUP_CYC = 8'(`FLHC_SETUP_CYC);
  localparam logic [7:0] PULSE_CYC = 8'(`FLHC_PULSE_CYC);
  localparam logic [7:0] ACCESS_CYC = 8'(`FLHC_ACCESS_CYC);

  flhc_reg_t r_q, r_d;
  logic [7:0] dq_m, dq_s;
  logic rb_m, rb_s;

  // pin inputs pass two flops before use
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dq_m <= 8'h00;
      dq_s <= 8'h00;
      rb_m <= 1'b1;
      rb_s <= 1'b1;
    end else begin
      dq_m <= data_bus_in;
      dq_s <= dq_m;
      rb_m <= ready_busy_out;
      rb_s <= rb_m;
    end
  end

  function automatic flhc_pins_t idle_pins(input logic [20:0] a);
    flhc_pins_t p;
    p.ce_n = 1'b1;
    p.oe_n = 1'b1;
    p.we_n = 1'b1;
    p.addr = a;
    p.dout = 8'h00;
    p.dout_en = 1'b0;
    return p;
  endfunction

  always_comb begin
    logic [7:0] code;
    code = 8'h00;
    r_d = r_q;
    r_d.rd_q = 32'h0000_0000;
    // software reads; data valid next cycle only
    if (sw_rd) begin
      case (sw_addr)
        `FLHC_REG_CTRL: r_d.rd_q = {28'h0000000, r_q.op};
        `FLHC_REG_ADDR: r_d.rd_q = {11'h000, r_q.addr};
        `FLHC_REG_WDATA: r_d.rd_q = {24'h000000, r_q.wdata};
        `FLHC_REG_STATUS: r_d.rd_q = {22'h000000, !rb_s, r_q.busy, r_q.stat};
        `FLHC_REG_RDATA: r_d.rd_q = {24'h000000, r_q.rdata};
        `FLHC_REG_ERRACC: r_d.rd_q = {29'h00000000, r_q.err_acc};
        default: r_d.rd_q = 32'h0000_0000;
      endcase
    end
    if (sw_wr) begin
      case (sw_addr)
        `FLHC_REG_ADDR: r_d.addr = sw_wdata[20:0];
        `FLHC_REG_WDATA: r_d.wdata = sw_wdata[7:0];
        // write-one clears the host-side error tally
        `FLHC_REG_ERRACC: r_d.err_acc = r_q.err_acc & ~sw_wdata[2:0];
        `FLHC_REG_CTRL: begin
          // orders while busy are dropped; software polls busy first
          if (!r_q.busy) begin
            r_d.op = sw_wdata[3:0];
            r_d.busy = (sw_wdata[3:0] != `FLHC_OP_NONE);
            r_d.phase = 2'd0;
          end
        end
        default: ;
      endcase
    end
    // command sequence per operation
    case (r_q.op)
      `FLHC_OP_CMD: code = r_q.wdata; // R20
      `FLHC_OP_CLEAR: code = `FLHC_CMD_CLEAR_STATUS; // R3
      `FLHC_OP_RESUME: code = `FLHC_CMD_ERASE_GO; // R21
      `FLHC_OP_PROGRAM: code = (r_q.phase == 2'd0) ? `FLHC_CMD_WRITE_SETUP : r_q.wdata; // R22
      `FLHC_OP_ERASE: code = (r_q.phase == 2'd0) ? `FLHC_CMD_ERASE_SETUP : `FLHC_CMD_ERASE_GO;
      `FLHC_OP_READ: code = 8'h00;
      default: code = 8'h00;
    endcase
    case (r_q.st)
      FLHC_IDLE: begin
        r_d.pins = idle_pins(r_q.addr);
        if (r_q.busy) begin
          r_d.cnt = 8'h00;
          if (r_q.op == `FLHC_OP_RESET) begin
            r_d.rst_n_out = 1'b0; // R1
            r_d.st = FLHC_RESET;
          end else if (r_q.op == `FLHC_OP_READ) begin
            r_d.st = FLHC_RD_SETUP;
          end else if (r_q.op == `FLHC_OP_CMD || r_q.op == `FLHC_OP_CLEAR ||
                       r_q.op == `FLHC_OP_RESUME || r_q.op == `FLHC_OP_PROGRAM ||
                       r_q.op == `FLHC_OP_ERASE) begin
            r_d.st = FLHC_SETUP;
          end else begin
            r_d.busy = 1'b0;
          end
        end
      end
      FLHC_SETUP: begin
        // oe high, ce and we low, data driven
        r_d.pins.oe_n = 1'b1; // R13
        r_d.pins.ce_n = 1'b0;
        r_d.pins.we_n = 1'b0;
        r_d.pins.dout = code;
        r_d.pins.dout_en = 1'b1;
        r_d.pins.addr = r_q.addr; // R7
        r_d.cnt = 8'h00;
        r_d.st = FLHC_PULSE;
      end
      FLHC_PULSE: begin
        r_d.cnt = r_q.cnt + 8'h01;
        if (r_q.cnt + 8'h01 >= PULSE_CYC) begin
          // rising we latches command or data
          r_d.pins.we_n = 1'b1; // R13
          r_d.cnt = 8'h00;
          r_d.st = FLHC_HOLD;
        end
      end
      FLHC_HOLD: begin
        r_d.pins = idle_pins(r_q.addr);
        r_d.st = FLHC_NEXT;
      end
      FLHC_NEXT: begin
        r_d.cnt = r_q.cnt + 8'h01;
        if (r_q.cnt + 8'h01 >= SETUP_CYC) begin
          r_d.cnt = 8'h00;
          if ((r_q.op == `FLHC_OP_PROGRAM || r_q.op == `FLHC_OP_ERASE) && r_q.phase == 2'd0) begin
            // second cycle follows the setup with nothing between
            r_d.phase = 2'd1; // R15
            r_d.st = FLHC_SETUP;
          end else if (r_q.op == `FLHC_OP_PROGRAM || r_q.op == `FLHC_OP_ERASE) begin
            // wait for ready, then read status: the device now serves status
            if (rb_s) begin // R5
              r_d.phase = 2'd2; // R11
              r_d.st = FLHC_RD_SETUP;
            end
          end else begin
            r_d.busy = 1'b0;
            r_d.op = `FLHC_OP_NONE;
            r_d.st = FLHC_IDLE;
          end
        end
      end
      FLHC_RD_SETUP: begin
        // array, status and id reads all use we high, oe ce low
        r_d.pins.we_n = 1'b1; // R8
        r_d.pins.ce_n = 1'b0;
        r_d.pins.oe_n = 1'b0; // R10
        r_d.pins.dout_en = 1'b0;
        r_d.pins.addr = r_q.addr; // R12
        r_d.cnt = 8'h00;
        r_d.st = FLHC_RD_WAIT;
      end
      FLHC_RD_WAIT: begin
        r_d.cnt = r_q.cnt + 8'h01;
        // two extra cycles for the input synchroniser
        if (r_q.cnt >= ACCESS_CYC + 8'h02) begin
          r_d.rdata = dq_s;
          r_d.st = FLHC_RD_END;
        end
      end
      FLHC_RD_END: begin
        // oe and ce raised so the next status read re-latches
        r_d.pins = idle_pins(r_q.addr); // R10
        if (r_q.phase == 2'd2) begin
          r_d.stat = r_q.rdata; // R19
          r_d.err_acc = r_d.err_acc | r_q.rdata[`FLHC_SR_ERASE_ERR:`FLHC_SR_SUPPLY_ERR]; // R4
        end
        r_d.busy = 1'b0;
        r_d.op = `FLHC_OP_NONE;
        r_d.st = FLHC_IDLE;
      end
      FLHC_RESET: begin
        r_d.cnt = r_q.cnt + 8'h01;
        if (r_q.cnt + 8'h01 >= PULSE_CYC) begin
          // device returns to array read with status clear
          r_d.rst_n_out = 1'b1; // R9
          r_d.stat = 8'h80;
          r_d.busy = 1'b0;
          r_d.op = `FLHC_OP_NONE;
          r_d.st = FLHC_IDLE;
        end
      end
      default: r_d.st = FLHC_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      r_q <= '{st: FLHC_IDLE, pins: '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
               addr: 21'h000000, dout: 8'h00, dout_en: 1'b0},
               cnt: 8'h00, op: 4'h0, phase: 2'd0, busy: 1'b0, addr: 21'h000000,
               wdata: 8'h00, rdata: 8'h00, stat: 8'h80, err_acc: 3'h0,
               rst_n_out: 1'b0, rd_q: 32'h0000_0000};
    end else begin
      r_q <= r_d;
    end
  end

  assign sw_rdata = r_q.rd_q;
  assign flash_ce_n = r_q.pins.ce_n;
  assign flash_oe_n = r_q.pins.oe_n;
  assign flash_we_n = r_q.pins.we_n;
  assign byte_address = r_q.pins.addr;
  assign data_bus_out = r_q.pins.dout;
  assign data_bus_oe = r_q.pins.dout_en;
  assign reset_powerdown_n = r_q.rst_n_out;

  a_cmd_oe_high: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !flash_we_n |-> flash_oe_n && !flash_ce_n && data_bus_oe) // R13
    else $error("command cycle without oe high");
  a_read_we_high: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !flash_oe_n |-> flash_we_n && !data_bus_oe) // R8
    else $error("read with we low or bus driven");
  a_write_follows: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (r_q.st == FLHC_NEXT && r_q.phase == 2'd0 && r_q.op == `FLHC_OP_PROGRAM)
    |-> ##[1:8] (r_q.st == FLHC_SETUP && r_q.phase == 2'd1)) // R15
    else $error("write cycle not right after setup");
  a_setup_code: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ($fell(flash_we_n) && r_q.op == `FLHC_OP_PROGRAM && r_q.phase == 2'd0)
    |-> data_bus_out == `FLHC_CMD_WRITE_SETUP) // R22
    else $error("wrong write setup code");
  a_erase_go: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ($fell(flash_we_n) && r_q.op == `FLHC_OP_ERASE && r_q.phase == 2'd1)
    |-> data_bus_out == `FLHC_CMD_ERASE_GO) // R21
    else $error("erase_go_cmd code wrong");
  a_err_sticky: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (r_q.err_acc != 3'h0 && !(sw_wr && sw_addr == `FLHC_REG_ERRACC))
    |=> (r_q.err_acc & $past(r_q.err_acc)) == $past(r_q.err_acc)) // R4
    else $error("error tally lost a bit");
  a_reset_pulse: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $fell(reset_powerdown_n) |-> !reset_powerdown_n [*2]) // R1
    else $error("reset pulse too short");
  a_addr_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!flash_we_n && !$past(flash_we_n)) |-> $stable(byte_address)) // R7
    else $error("address moved during write pulse");
  c_program: cover property (@(posedge sys_clk) disable iff (!rst_b)
    r_q.op == `FLHC_OP_PROGRAM && r_q.st == FLHC_RD_END);
  c_erase: cover property (@(posedge sys_clk) disable iff (!rst_b)
    r_q.op == `FLHC_OP_ERASE && r_q.st == FLHC_RD_END);
  c_read: cover property (@(posedge sys_clk) disable iff (!rst_b)
    r_q.op == `FLHC_OP_READ && r_q.st == FLHC_RD_END);
endmodule
`default_nettype wire

// file: rtl/flhc_params.svh
/*
  timing counts and encodings for the flash host controller.
  assumes a 40 MHz sys_clk; included by the controller, the flash model and the bench.
*/
`ifndef FLHC_PARAMS_SVH
`define FLHC_PARAMS_SVH
`define FLHC_CLK_MHZ 40
`define FLHC_T_SETUP_NS 50
`define FLHC_T_PULSE_NS 75
`define FLHC_T_ACCESS_NS 100
`define FLHC_SETUP_CYC ((`FLHC_T_SETUP_NS * `FLHC_CLK_MHZ + 999) / 1000)
`define FLHC_PULSE_CYC ((`FLHC_T_PULSE_NS * `FLHC_CLK_MHZ + 999) / 1000)
`define FLHC_ACCESS_CYC ((`FLHC_T_ACCESS_NS * `FLHC_CLK_MHZ + 999) / 1000)
`define FLHC_CMD_READ_ARRAY 8'hFF
`define FLHC_CMD_READ_ID 8'h90
`define FLHC_CMD_READ_STATUS 8'h70
`define FLHC_CMD_CLEAR_STATUS 8'h50
`define FLHC_CMD_ERASE_SETUP 8'h20
`define FLHC_CMD_ERASE_GO 8'hD0
`define FLHC_CMD_WRITE_SETUP 8'h40
`define FLHC_CMD_WRITE_SETUP_ALT 8'h10
`define FLHC_CMD_ERASE_SUSPEND 8'hB0
`define FLHC_ADDR_MAKER_CODE 21'h000000
`define FLHC_ADDR_PART_CODE 21'h000001
`define FLHC_SR_READY 7
`define FLHC_SR_SUSPENDED 6
`define FLHC_SR_ERASE_ERR 5
`define FLHC_SR_WRITE_ERR 4
`define FLHC_SR_SUPPLY_ERR 3
`define FLHC_REG_CTRL 4'h0
`define FLHC_REG_ADDR 4'h1
`define FLHC_REG_WDATA 4'h2
`define FLHC_REG_STATUS 4'h3
`define FLHC_REG_RDATA 4'h4
`define FLHC_REG_ERRACC 4'h5
`define FLHC_OP_NONE 4'h0
`define FLHC_OP_CMD 4'h1
`define FLHC_OP_READ 4'h2
`define FLHC_OP_PROGRAM 4'h3
`define FLHC_OP_ERASE 4'h4
`define FLHC_OP_CLEAR 4'h5
`define FLHC_OP_RESET 4'h6
`define FLHC_OP_RESUME 4'h7
`endif

// file: rtl/flhc_pkg.sv
/*
  types for the flash host controller.
  assumes flhc_params.svh for constants.
*/
package flhc_pkg;
  typedef enum logic [3:0] {
    FLHC_IDLE, FLHC_SETUP, FLHC_PULSE, FLHC_HOLD, FLHC_RD_SETUP, FLHC_RD_WAIT,
    FLHC_RD_END, FLHC_NEXT, FLHC_RESET
  } flhc_state_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [20:0] addr;
    logic [7:0] dout;
    logic dout_en;
  } flhc_pins_t;

  typedef struct packed {
    flhc_state_t st;
    flhc_pins_t pins;
    logic [7:0] cnt;
    logic [3:0] op;
    logic [1:0] phase;
    logic busy;
    logic [20:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] stat;
    logic [2:0] err_acc;
    logic rst_n_out;
    logic [31:0] rd_q;
  } flhc_reg_t;
endpackage

// file: verif/flhc_flash_model.sv
/*
  behavioural byte-wide flash standing at the controller's pins.
  assumes flhc_ctrl drives the pins; a released bus shows inverted last data.
*/
`timescale 1ns/1ps
`default_nettype none
`include "flhc_params.svh"
module flhc_flash_model #(
  parameter logic [7:0] MAKER = 8'h3E, // arbitrary value
  parameter logic [7:0] PART = 8'hC7, // arbitrary value
  parameter int BUSY_NS = 400
) (
  // flash pins
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic rp_n,
  input wire logic [20:0] addr,
  input wire logic [7:0] din,
  output logic [7:0] dq,
  output logic rdy,
  // fault controls
  input wire logic fail_wr,
  input wire logic no_supply
);
  logic [7:0] mem [256];
  logic [2:0] err;
  logic [1:0] mode;
  logic [1:0] pend;
  logic [7:0] lat;
  logic [7:0] q;
  logic [7:0] q_last;
  logic [7:0] sr;
  // small array: block bits plus low byte bits
  function automatic logic [7:0] idx(input logic [20:0] a);
    return {a[20:16], a[2:0]};
  endfunction
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    rdy = 1'b1;
    q_last = 8'h00;
  end
  assign sr = {rdy, 1'b0, err, 3'h0};
  always @(negedge rp_n or posedge we_n) begin
    if (!rp_n) begin
      err = 3'h0;
      mode = 2'd0;
      pend = 2'd0;
      rdy = 1'b1;
    end else if (!ce_n && oe_n && rdy) begin
      if (pend != 2'd0) begin
        if (pend == 2'd1) begin
          mem[idx(addr)] = mem[idx(addr)] & din;
        end else if (din == `FLHC_CMD_ERASE_GO) begin
          for (int i = 0; i < 8; i++) mem[{addr[20:16], i[2:0]}] = 8'hFF;
        end
        err = err | {1'b0, fail_wr && pend == 2'd1, no_supply};
        mode = 2'd2;
        pend = 2'd0;
        rdy = 1'b0;
        rdy <= #BUSY_NS 1'b1;
      end else begin
        case (din)
          `FLHC_CMD_READ_ARRAY: mode = 2'd0;
          `FLHC_CMD_READ_ID: mode = 2'd1;
          `FLHC_CMD_READ_STATUS: mode = 2'd2;
          `FLHC_CMD_CLEAR_STATUS: err = 3'h0;
          `FLHC_CMD_ERASE_SETUP: pend = 2'd2;
          `FLHC_CMD_WRITE_SETUP, `FLHC_CMD_WRITE_SETUP_ALT: pend = 2'd1;
          default: ;
        endcase
      end
    end
  end
  // status held until an enable is toggled
  always @(negedge oe_n or negedge ce_n) if (!oe_n && !ce_n) lat = sr;
  always @* begin
    q = mode == 2'd0 ? mem[idx(addr)] : mode == 2'd1 ? (addr[0] ? PART : MAKER) : lat;
    if (!ce_n && !oe_n && rp_n) q_last = q;
  end
  assign dq = (!ce_n && !oe_n && we_n && rp_n) ? q : ~q_last;
endmodule
`default_nettype wire

// file: verif/tb_flash_command_and_read_interface.sv
/*
  bench for flhc_ctrl: register calls over the strobe port.
  assumes flhc_flash_model on the flash pins.
*/
`timescale 1ns/1ps
`default_nettype none
`include "flhc_params.svh"
module tb_flash_command_and_read_interface;
  import flhc_pkg::*;
  localparam logic [7:0] MK = 8'h5B; // arbitrary value
  localparam logic [7:0] PT = 8'h2D; // arbitrary value
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] sw_addr = 4'h0;
  logic [31:0] sw_wdata = 32'h0;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic fail_wr = 1'b0;
  logic no_supply = 1'b0;
  logic [31:0] sw_rdata;
  logic ce_n, oe_n, we_n, dboe, rp_n, rdy;
  logic [20:0] fa;
  logic [7:0] dbo, dq, bus;
  int mismatches = 0;
  int checked = 0;
  always #12.5 sys_clk = ~sys_clk;
  assign bus = dboe ? dbo : dq;
  flhc_ctrl dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
    .flash_we_n(we_n), .byte_address(fa), .data_bus_out(dbo), .data_bus_oe(dboe),
    .data_bus_in(bus), .reset_powerdown_n(rp_n), .ready_busy_out(rdy));
  flhc_flash_model #(.MAKER(MK), .PART(PT)) flash_u (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .rp_n(rp_n), .addr(fa), .din(bus), .dq(dq), .rdy(rdy), .fail_wr(fail_wr),
    .no_supply(no_supply));
  task automatic close_out();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge sys_clk);
    sw_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge sys_clk);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask
  // bounded wait on the busy flag
  task automatic op(input logic [3:0] o);
    logic [31:0] s;
    int n;
    wr(`FLHC_REG_CTRL, {28'h0, o});
    repeat (2) @(posedge sys_clk);
    for (n = 0; n < 500; n++) begin
      rd(`FLHC_REG_STATUS, s);
      if (s[8] === 1'b0) break;
    end
    if (n == 500) begin
      mismatches++;
      $display("MISMATCH at %0t: busy never cleared", $time);
      close_out();
    end
  endtask
  task automatic cmd(input logic [7:0] c);
    wr(`FLHC_REG_WDATA, {24'h0, c});
    op(`FLHC_OP_CMD);
  endtask
  task automatic prog(input logic [20:0] a, input logic [7:0] d);
    wr(`FLHC_REG_ADDR, {11'h0, a});
    wr(`FLHC_REG_WDATA, {24'h0, d});
    op(`FLHC_OP_PROGRAM);
  endtask
  task automatic rchk(input logic [20:0] a, input logic [7:0] e);
    logic [31:0] v;
    wr(`FLHC_REG_ADDR, {11'h0, a});
    op(`FLHC_OP_READ);
    rd(`FLHC_REG_RDATA, v);
    chk(v, {24'h0, e});
  endtask
  task automatic schk(input logic [7:0] e);
    logic [31:0] v;
    rd(`FLHC_REG_STATUS, v);
    chk({24'h0, v[7:0]}, {24'h0, e});
  endtask
  initial begin
    logic [31:0] v;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    op(`FLHC_OP_RESET);
    rchk(21'h5, 8'hFF);
    cmd(`FLHC_CMD_READ_ID);
    rchk(`FLHC_ADDR_MAKER_CODE, MK);
    rchk(`FLHC_ADDR_PART_CODE, PT);
    cmd(`FLHC_CMD_READ_ARRAY);
    prog(21'h5, 8'hA5);
    schk(8'h80);
    cmd(`FLHC_CMD_READ_ARRAY);
    rchk(21'h5, 8'hA5);
    prog(21'h5, 8'h5A);
    cmd(`FLHC_CMD_READ_ARRAY);
    rchk(21'h5, 8'h00);
    fail_wr <= 1'b1;
    prog(21'h6, 8'hF0);
    fail_wr <= 1'b0;
    prog(21'h7, 8'h0F);
    schk(8'h90);
    rd(`FLHC_REG_ERRACC, v);
    chk(v, 32'h2);
    wr(`FLHC_REG_ERRACC, 32'h7);
    rd(`FLHC_REG_ERRACC, v);
    chk(v, 32'h0);
    op(`FLHC_OP_CLEAR);
    cmd(`FLHC_CMD_READ_STATUS);
    rchk(21'h0, 8'h80);
    prog(21'h10005, 8'h3C);
    wr(`FLHC_REG_ADDR, 32'h5);
    op(`FLHC_OP_ERASE);
    cmd(`FLHC_CMD_READ_ARRAY);
    rchk(21'h5, 8'hFF);
    rchk(21'h10005, 8'h3C);
    no_supply <= 1'b1;
    op(`FLHC_OP_ERASE);
    no_supply <= 1'b0;
    schk(8'h88);
    op(`FLHC_OP_RESUME);
    rchk(21'h0, 8'h88);
    rd(`FLHC_REG_CTRL, v);
    chk(v, 32'h0);
    // pin pulse while high: status and mode must both return to defaults
    op(`FLHC_OP_RESET);
    rchk(21'h10005, 8'hFF);
    cmd(`FLHC_CMD_READ_STATUS);
    rchk(21'h0, 8'h80);
    // controller reset in mid-run also drops the flash reset pin
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(`FLHC_REG_STATUS, v);
    chk(v, 32'h80);
    op(`FLHC_OP_RESET);
    rchk(21'h5, 8'hFF);
    rd(4'h7, v);
    chk(v, 32'h0);
    close_out();
  end
endmodule
`default_nettype wire
